// file: flash_host_pkg.sv
package flash_host_pkg;
   // bus geometry
   localparam int ADDR_W = 21;
   localparam int DATA_W = 16;
   localparam int CLK_PERIOD_NS = 25;
   // timing figures in ns, cycle counts derived (least times round up)
   localparam int ADDRESS_ACCESS_TIME_NS = 70;
   localparam int SELECT_ACCESS_TIME_NS = 70;
   localparam int OUTPUT_ACCESS_TIME_NS = 30;
   localparam int WRITE_PULSE_NS = 35;
   localparam int WRITE_HIGH_NS = 30;
   localparam int RESET_PULSE_MIN_NS = 500;
   localparam int RESET_TO_READ_DELAY_NS = 50;
   localparam int READ_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WHIGH_CYC = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RH_CYC = (RESET_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   // user operation codes
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_WRITE = 3'h1;
   localparam logic [2:0] OP_RESET = 3'h2;
   localparam logic [2:0] OP_ACCEL_WRITE = 3'h3;
   localparam logic [2:0] OP_HV_WRITE = 3'h4;
   localparam logic [2:0] OP_VERIFY = 3'h5;
   localparam logic [2:0] OP_ALT_PROTECT = 3'h6;
   // address line positions
   localparam int ADDR_LINE_ONE = 1;
   localparam int ADDR_LINE_SIX = 6;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_READ = 6'h02,
      ST_WLOW = 6'h04,
      ST_WHIGH = 6'h08,
      ST_RST = 6'h10,
      ST_RH = 6'h20
   } state_t;
endpackage

// file: flash_host.sv
`timescale 1ns/1ps
module flash_host #(
   parameter int RST_CYCLES = flash_host_pkg::RST_CYC
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic [2:0] req_op,
   input wire logic [flash_host_pkg::ADDR_W-1:0] req_addr,
   input wire logic [flash_host_pkg::DATA_W-1:0] req_wdata,
   input wire logic standby_req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [flash_host_pkg::DATA_W-1:0] rsp_rdata,
   output logic busy,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic flash_reset_n,
   output logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
   output logic [flash_host_pkg::DATA_W-1:0] flash_dq_out,
   output logic flash_dq_oe_n,
   output logic reset_hv_en,
   output logic line_nine_hv_en,
   output logic oe_hv_en,
   output logic protect_accel_pin,
   output logic accel_hv_en,
   input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_in,
   input wire logic completion_indicator
);
   flash_host_pkg::state_t st_ff, nxt_st;
   logic [flash_host_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [2:0] op_ff, nxt_op;
   logic ce_n_ff, nxt_ce_n, oe_n_ff, nxt_oe_n, we_n_ff, nxt_we_n, rn_ff, nxt_rn;
   logic [flash_host_pkg::ADDR_W-1:0] a_ff, nxt_a;
   logic [flash_host_pkg::DATA_W-1:0] d_ff, nxt_d, rd_ff, nxt_rd;
   logic dqoe_n_ff, nxt_dqoe_n, rhv_ff, nxt_rhv, a9hv_ff, nxt_a9hv, oehv_ff, nxt_oehv;
   logic acc_ff, nxt_acc, rdy_ff, nxt_rdy, rv_ff, nxt_rv, busy_ff, nxt_busy;
   logic [flash_host_pkg::DATA_W-1:0] dq_s1_ff, dq_s2_ff;
   logic cmp_s1_ff, cmp_s2_ff;

   // pin inputs pass two flops; first stage feeds only the second
   always_ff @(posedge clk)
   begin
      dq_s1_ff <= flash_dq_in;
      dq_s2_ff <= dq_s1_ff;
      cmp_s1_ff <= completion_indicator;
      cmp_s2_ff <= cmp_s1_ff;
   end

   // sequencer: one request at a time, pins stepped by counted cycles
   always_comb
   begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_op = op_ff;
      nxt_ce_n = ce_n_ff;
      nxt_oe_n = oe_n_ff;
      nxt_we_n = we_n_ff;
      nxt_rn = rn_ff;
      nxt_a = a_ff;
      nxt_d = d_ff;
      nxt_rd = rd_ff;
      nxt_dqoe_n = dqoe_n_ff;
      nxt_rhv = rhv_ff;
      nxt_a9hv = a9hv_ff;
      nxt_oehv = oehv_ff;
      nxt_acc = acc_ff;
      nxt_rdy = 1'b0;
      nxt_rv = 1'b0;
      nxt_busy = ~cmp_s2_ff;
      case (st_ff)
         flash_host_pkg::ST_IDLE:
         begin
            // idle: select released when asked, keeping the device in standby
            nxt_ce_n = standby_req;
            nxt_oe_n = 1'b1;
            nxt_we_n = 1'b1;
            nxt_dqoe_n = 1'b1;
            nxt_rhv = 1'b0;
            nxt_a9hv = 1'b0;
            nxt_oehv = 1'b0;
            nxt_acc = 1'b0; // accel level dropped outside accelerated writes
            nxt_rdy = 1'b1;
            if (req_valid && rdy_ff)
            begin
               nxt_rdy = 1'b0;
               nxt_op = req_op;
               nxt_a = req_addr;
               nxt_d = req_wdata;
               nxt_ce_n = 1'b0;
               case (req_op)
                  flash_host_pkg::OP_RESET:
                  begin
                     // ready returns only once reset has completed, so the caller can reissue a cut write
                     nxt_ce_n = 1'b1;
                     nxt_rn = 1'b0; // hold reset low for the minimum pulse
                     nxt_cnt = RST_CYCLES[flash_host_pkg::CNT_W-1:0];
                     nxt_st = flash_host_pkg::ST_RST;
                  end
                  flash_host_pkg::OP_READ, flash_host_pkg::OP_VERIFY:
                  begin
                     nxt_oe_n = 1'b0; // select and gate low, strobe high
                     nxt_a9hv = (req_op == flash_host_pkg::OP_VERIFY);
                     if (req_op == flash_host_pkg::OP_VERIFY)
                        nxt_a[flash_host_pkg::ADDR_LINE_ONE] = 1'b1;
                     // one extra count: the first sync flop must not capture before the full access time
                     nxt_cnt = flash_host_pkg::READ_CYC[flash_host_pkg::CNT_W-1:0] + 8'h01;
                     nxt_st = flash_host_pkg::ST_READ;
                  end
                  default:
                  begin
                     nxt_we_n = 1'b0; // strobe and select low, gate high
                     nxt_dqoe_n = 1'b0;
                     nxt_acc = (req_op == flash_host_pkg::OP_ACCEL_WRITE);
                     // protect-all before unprotect is left to the caller's order of requests
                     nxt_rhv = (req_op == flash_host_pkg::OP_HV_WRITE); // reset pin only
                     if (req_op == flash_host_pkg::OP_ALT_PROTECT)
                     begin
                        nxt_a9hv = 1'b1; // line nine and gate at high voltage
                        nxt_oehv = 1'b1;
                        nxt_a[flash_host_pkg::ADDR_LINE_SIX] = 1'b0;
                     end
                     nxt_cnt = flash_host_pkg::WRITE_CYC[flash_host_pkg::CNT_W-1:0];
                     nxt_st = flash_host_pkg::ST_WLOW;
                  end
               endcase
            end
         end
         flash_host_pkg::ST_READ:
         begin
            nxt_cnt = cnt_ff - 1'b1;
            // sample after two extra cycles to cover the input synchroniser
            if (cnt_ff == '0)
            begin
               nxt_rd = dq_s2_ff;
               nxt_rv = 1'b1;
               nxt_oe_n = 1'b1;
               nxt_a9hv = 1'b0;
               nxt_st = flash_host_pkg::ST_IDLE;
            end
         end
         flash_host_pkg::ST_WLOW:
         begin
            nxt_cnt = cnt_ff - 1'b1;
            if (cnt_ff == 8'h01)
            begin
               nxt_we_n = 1'b1; // rising edge latches data, ends protection pulse
               nxt_cnt = flash_host_pkg::WHIGH_CYC[flash_host_pkg::CNT_W-1:0];
               nxt_st = flash_host_pkg::ST_WHIGH;
            end
         end
         flash_host_pkg::ST_WHIGH:
         begin
            nxt_cnt = cnt_ff - 1'b1;
            if (cnt_ff == 8'h01)
            begin
               nxt_dqoe_n = 1'b1;
               nxt_rv = 1'b1;
               nxt_st = flash_host_pkg::ST_IDLE;
            end
         end
         flash_host_pkg::ST_RST:
         begin
            nxt_cnt = cnt_ff - 1'b1;
            if (cnt_ff == 8'h01)
            begin
               nxt_rn = 1'b1;
               nxt_cnt = flash_host_pkg::RH_CYC[flash_host_pkg::CNT_W-1:0];
               nxt_st = flash_host_pkg::ST_RH;
            end
         end
         flash_host_pkg::ST_RH:
         begin
            // no read before reset-to-read delay and completion indicator high
            if (cnt_ff != '0)
               nxt_cnt = cnt_ff - 1'b1;
            else if (cmp_s2_ff)
            begin
               nxt_rv = 1'b1;
               nxt_st = flash_host_pkg::ST_IDLE;
            end
         end
         default:
            nxt_st = flash_host_pkg::ST_IDLE;
      endcase
   end

   // registers; reset leaves pins idle and the flash out of reset
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_ff <= flash_host_pkg::ST_IDLE;
         cnt_ff <= '0;
         op_ff <= flash_host_pkg::OP_READ;
         ce_n_ff <= 1'b1;
         oe_n_ff <= 1'b1;
         we_n_ff <= 1'b1;
         rn_ff <= 1'b1;
         a_ff <= '0;
         d_ff <= '0;
         rd_ff <= '0;
         dqoe_n_ff <= 1'b1;
         rhv_ff <= 1'b0;
         a9hv_ff <= 1'b0;
         oehv_ff <= 1'b0;
         acc_ff <= 1'b0;
         rdy_ff <= 1'b0;
         rv_ff <= 1'b0;
         busy_ff <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         op_ff <= nxt_op;
         ce_n_ff <= nxt_ce_n;
         oe_n_ff <= nxt_oe_n;
         we_n_ff <= nxt_we_n;
         rn_ff <= nxt_rn;
         a_ff <= nxt_a;
         d_ff <= nxt_d;
         rd_ff <= nxt_rd;
         dqoe_n_ff <= nxt_dqoe_n;
         rhv_ff <= nxt_rhv;
         a9hv_ff <= nxt_a9hv;
         oehv_ff <= nxt_oehv;
         acc_ff <= nxt_acc;
         rdy_ff <= nxt_rdy;
         rv_ff <= nxt_rv;
         busy_ff <= nxt_busy;
      end
   end

   assign req_ready = rdy_ff;
   assign rsp_valid = rv_ff;
   assign rsp_rdata = rd_ff;
   assign busy = busy_ff;
   assign flash_ce_n = ce_n_ff;
   assign flash_oe_n = oe_n_ff;
   assign flash_we_n = we_n_ff;
   assign flash_reset_n = rn_ff;
   assign flash_addr = a_ff;
   assign flash_dq_out = d_ff;
   assign flash_dq_oe_n = dqoe_n_ff;
   assign reset_hv_en = rhv_ff;
   assign line_nine_hv_en = a9hv_ff;
   assign oe_hv_en = oehv_ff;
   assign protect_accel_pin = 1'b1;
   assign accel_hv_en = acc_ff;
endmodule

// file: flash_host_sva.sv
`timescale 1ns/1ps
module flash_host_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic [2:0] req_op,
   input wire logic standby_req,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic flash_reset_n,
   input wire logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
   input wire logic line_nine_hv_en,
   input wire logic oe_hv_en,
   input wire logic accel_hv_en,
   input wire logic flash_dq_oe_n
);
   logic [flash_host_pkg::CNT_W-1:0] low_cnt_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // length of the current reset pulse in cycles, saturating so long pulses cannot wrap
   always_ff @(posedge clk)
   begin
      if (rst || flash_reset_n)
         low_cnt_ff <= '0;
      else if (low_cnt_ff != '1)
         low_cnt_ff <= low_cnt_ff + 1'b1;
   end
   // pin levels for reads and writes; the alternate protect lifts the gate, so it is excluded
   property p_rd;
      !flash_oe_n && !oe_hv_en |-> !flash_ce_n && flash_we_n;
   endproperty
   a_rd: assert property (p_rd) else $error("read pins wrong");
   property p_wr;
      !flash_we_n |-> !flash_ce_n && (flash_oe_n || oe_hv_en);
   endproperty
   a_wr: assert property (p_wr) else $error("write pins wrong");
   property p_rlat;
      req_valid && req_ready && req_op == flash_host_pkg::OP_READ |-> ##6 rsp_valid;
   endproperty
   a_rlat: assert property (p_rlat) else $error("read latency");
   property p_rst;
      $fell(flash_reset_n) |-> !flash_reset_n [*3];
   endproperty
   a_rst: assert property (p_rst) else $error("reset pulse short");
   property p_rh;
      $rose(flash_reset_n) |-> !rsp_valid [*2];
   endproperty
   a_rh: assert property (p_rh) else $error("done before read delay");
   property p_alt;
      oe_hv_en |-> line_nine_hv_en && !flash_addr[flash_host_pkg::ADDR_LINE_SIX];
   endproperty
   a_alt: assert property (p_alt) else $error("alt protect pins");
   property p_ver;
      line_nine_hv_en && !oe_hv_en |-> flash_addr[flash_host_pkg::ADDR_LINE_ONE];
   endproperty
   a_ver: assert property (p_ver) else $error("verify line one low");
   property p_sby;
      standby_req && req_ready && !req_valid |=> flash_ce_n;
   endproperty
   a_sby: assert property (p_sby) else $error("select low in standby");
   property p_rpw;
      $rose(flash_reset_n) |-> low_cnt_ff >= flash_host_pkg::RST_CYC;
   endproperty
   a_rpw: assert property (p_rpw) else $error("reset pulse below minimum");
   property p_acc;
      accel_hv_en |-> !flash_ce_n && flash_oe_n;
   endproperty
   a_acc: assert property (p_acc) else $error("accel level outside a write");
   property p_dq;
      !flash_dq_oe_n |-> flash_oe_n;
   endproperty
   a_dq: assert property (p_dq) else $error("host drives data with gate low");
endmodule
bind flash_host flash_host_sva flash_host_sva_inst (.*);

// file: flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model (
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic flash_reset_n,
   input wire logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
   input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_out,
   input wire logic reset_hv_en,
   input wire logic line_nine_hv_en,
   input wire logic oe_hv_en,
   input wire logic accel_hv_en,
   output logic [flash_host_pkg::DATA_W-1:0] flash_dq_in,
   output logic completion_indicator
);
   logic [15:0] mem [16];
   logic [15:0] val;
   logic prot;
   logic drive;
   logic accel_used;
   // power-up contents, array read mode, nothing protected
   initial
   begin
      foreach (mem[i]) mem[i] = 16'h1000 + 16'(i);
      prot = 1'b0;
      accel_used = 1'b0;
      completion_indicator = 1'b1;
   end
   // hv on line nine is its own condition; line one high then reads protection on bit zero
   assign val = (line_nine_hv_en && flash_addr[1]) ? {15'h0, prot} : mem[flash_addr[3:0]];
   // outputs follow the address at once, so the automatic low-power read is invisible here
   assign drive = !flash_ce_n && !flash_oe_n && flash_we_n && flash_reset_n;
   // a released bus shows the inverse so a stale sample cannot pass
   assign flash_dq_in = drive ? val : ~val;
   // strobe rising edge commits; reset-pin hv protects with line six low, unprotects with it high
   always @(posedge flash_we_n)
   begin
      if (!flash_ce_n && reset_hv_en)
         prot = !flash_addr[6];
      else if (!flash_ce_n && oe_hv_en && line_nine_hv_en && !flash_addr[6])
         prot = 1'b1;
      else if (!flash_ce_n && !prot)
         mem[flash_addr[3:0]] = flash_dq_out;
      if (!flash_ce_n)
         accel_used = accel_hv_en;
   end
   // internal reset keeps completion low for a while after the pin returns
   always @(flash_reset_n)
   begin
      if (!flash_reset_n)
         completion_indicator = 1'b0;
      else
         #110 completion_indicator = 1'b1; // off the clock grid, so no race with a sampling edge
   end
endmodule

// file: tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin fails++; $display("Error %s exp %h got %h", n, e, a); end end
module tb;
   logic clk, rst, req_valid, standby_req, req_ready, rsp_valid, busy;
   logic flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, flash_dq_oe_n, completion_indicator;
   logic reset_hv_en, line_nine_hv_en, oe_hv_en, protect_accel_pin, accel_hv_en;
   logic [2:0] req_op;
   logic [20:0] req_addr, flash_addr;
   logic [15:0] req_wdata, rsp_rdata, flash_dq_out, flash_dq_in, rd;
   int fails, n_compared;
   time t0;
   flash_host flash_host_inst (.*);
   flash_dev_model flash_dev_model_inst (.*);
   // 40 MHz
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task end_of_test;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // inputs move 2 ns after the edge, outputs are read there too
   task step;
      @(posedge clk);
      #2;
   endtask
   // hold the request until taken, then wait a bounded time for the answer
   task op(input logic [2:0] o, input logic [20:0] a, input logic [15:0] d);
      int n;
      req_op = o;
      req_addr = a;
      req_wdata = d;
      req_valid = 1'b1;
      for (n = 0; n < 50 && req_ready !== 1'b1; n++) step();
      step();
      req_valid = 1'b0;
      for (n = 0; n < 100 && rsp_valid !== 1'b1; n++) step();
      `CHK("response", 1'b1, rsp_valid)
      rd = rsp_rdata;
   endtask
   // cut a hang short; the run needs a few microseconds
   initial
   begin
      #20000;
      fails++;
      end_of_test();
   end
   // main sequence
   initial
   begin
      fails = 0;
      n_compared = 0;
      rst = 1'b1;
      req_valid = 1'b0;
      standby_req = 1'b0;
      req_op = 3'h0;
      req_addr = 21'h0;
      req_wdata = 16'h0;
      repeat (2) @(posedge clk);
      #2;
      rst = 1'b0;
      op(flash_host_pkg::OP_READ, 21'h5, 16'h0);
      `CHK("power-up read", 16'h1005, rd)
      op(flash_host_pkg::OP_WRITE, 21'h5, 16'hBEEF);
      `CHK("no accel on plain write", 1'b0, flash_dev_model_inst.accel_used)
      op(flash_host_pkg::OP_READ, 21'h5, 16'h0);
      `CHK("written word", 16'hBEEF, rd)
      op(flash_host_pkg::OP_ACCEL_WRITE, 21'hF, 16'hFFFF);
      `CHK("accel level used", 1'b1, flash_dev_model_inst.accel_used)
      op(flash_host_pkg::OP_READ, 21'hF, 16'h0);
      `CHK("accel word", 16'hFFFF, rd)
      op(flash_host_pkg::OP_VERIFY, 21'h0, 16'h0);
      `CHK("verify unprotected", 16'h0000, rd)
      op(flash_host_pkg::OP_HV_WRITE, 21'h0, 16'h0060);
      op(flash_host_pkg::OP_VERIFY, 21'h0, 16'h0);
      `CHK("verify protected", 16'h0001, rd)
      op(flash_host_pkg::OP_WRITE, 21'h5, 16'h0000);
      op(flash_host_pkg::OP_READ, 21'h5, 16'h0);
      `CHK("protected word kept", 16'hBEEF, rd)
      t0 = $time;
      op(flash_host_pkg::OP_RESET, 21'h0, 16'h0);
      `CHK("reset waits for completion", 1'b1, ($time - t0) >= 200)
      `CHK("completion high at done", 1'b1, completion_indicator)
      `CHK("busy clear at done", 1'b0, busy)
      op(flash_host_pkg::OP_READ, 21'h5, 16'h0);
      `CHK("read after reset", 16'hBEEF, rd)
      standby_req = 1'b1;
      repeat (3) step();
      `CHK("standby select", 1'b1, flash_ce_n)
      standby_req = 1'b0;
      // all was protected above, so now unprotect the chip with line six high
      op(flash_host_pkg::OP_HV_WRITE, 21'h40, 16'h0);
      op(flash_host_pkg::OP_VERIFY, 21'h0, 16'h0);
      `CHK("verify after unprotect", 16'h0000, rd)
      op(flash_host_pkg::OP_WRITE, 21'h5, 16'h1234);
      op(flash_host_pkg::OP_READ, 21'h5, 16'h0);
      `CHK("reissued word", 16'h1234, rd)
      op(flash_host_pkg::OP_ALT_PROTECT, 21'h40, 16'h0);
      op(flash_host_pkg::OP_VERIFY, 21'h0, 16'h0);
      `CHK("verify after alt protect", 16'h0001, rd)
      end_of_test();
   end
endmodule
